// file: logic/wkc_pkg.sv
package wkc_pkg;
  // register word addresses (one per 32-bit register)
  localparam logic [3:0] ADDR_PORT_EVENT_SELECT  = 4'h0;
  localparam logic [3:0] ADDR_PORT_EDGE_POLARITY = 4'h1;
  localparam logic [3:0] ADDR_WAKEUP_CONTROL     = 4'h2;
  localparam logic [3:0] ADDR_EVENT_COMPARE      = 4'h3;
  localparam logic [3:0] ADDR_IRQ_CLEAR          = 4'h4;
  localparam logic [3:0] ADDR_COUNTER_CLEAR      = 4'h5;
  localparam logic [3:0] ADDR_EVENT_COUNT        = 4'h6;
  localparam logic [3:0] ADDR_STATUS             = 4'h7;
  // wakeup_control fields
  localparam int DEB_LSB     = 0;
  localparam int DEB_W       = 6;
  localparam int IRQ_EN_BIT  = 7;
  localparam int CTRL_W      = 8;
  localparam int CNT_W       = 8;
  // timing
  localparam int TICK_MS        = 1;
  localparam int CLK_KHZ        = 10000;
  localparam int TICK_CYCLES    = TICK_MS * CLK_KHZ;
  localparam logic [31:0] ZERO32 = 32'h0000_0000;
  typedef enum logic [1:0] {
    WKC_IDLE,
    WKC_DEBOUNCE,
    WKC_WAIT_RELEASE
  } wkc_state_type;
endpackage

// file: logic/wkc_event_counter.sv
// What this block does
// RQ1: each gpio input is enabled as an event source by its select bit.
// RQ2: a per-port polarity bit chooses which edge of an input is active.
// RQ3: polarity 0 makes a rising edge on a selected input a key hit.
// RQ4: polarity 1 makes a falling edge on a selected input a key hit.
// RQ5: a key hit loads the debounce down-counter from debounce_value.
// RQ6: the debounce counter steps down once per 1 ms tick.
// RQ7: debounce_value is six bits wide, giving 0 to 63 ms.
// RQ8: the count rises only if debounce ends with the key hit still held.
// RQ9: after counting, the machine waits for the reverse edge before idle.
// RQ10: count equal to a nonzero compare clears the count and raises the enabled irq.
// RQ11: any write to the irq clear strobe clears the pending interrupt; a write in the same cycle as a new enabled match leaves irq set.
// RQ12: any write to the counter clear strobe zeroes the event count.
// RQ13: the event count is readable at any time without side effects.
// RQ14: the interrupt goes out on a pin to wake the processor.
// RQ15: gpio inputs pass a two-stage synchroniser before edge detection.
//
// The placing of the registers and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
module wkc_event_counter
  import wkc_pkg::*;
#(
  parameter int N_GPIO      = 8,
  parameter int TICK_PERIOD = TICK_CYCLES
) (
  // clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  // avalon-mm slave
  input  wire logic [3:0]        avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [31:0]       avs_writedata_i,
  output logic      [31:0]       avs_readdata_o,
  output logic                   avs_waitrequest_o,
  // gpio and interrupt
  input  wire logic [N_GPIO-1:0] gpio_i,
  output logic                   wakeup_irq_o
);

  logic [N_GPIO-1:0] sync1_r, sync2_r, prev_r;
  logic [N_GPIO-1:0] sel_r, sel_nxt, pol_r, pol_nxt;
  logic [CTRL_W-1:0] ctrl_r, ctrl_nxt;
  logic [CNT_W-1:0]  cmp_r, cmp_nxt, cnt_r, cnt_nxt;
  logic [DEB_W-1:0]  deb_r, deb_nxt;
  logic [31:0]       tick_cnt_r, tick_cnt_nxt;
  logic              tick_r, tick_nxt, irq_r, irq_nxt;
  logic              ack_r, ack_nxt;
  logic [31:0]       rdata_r, rdata_nxt;
  wkc_state_type     state_r, state_nxt;
  logic [N_GPIO-1:0] active_lvl, act_edge, rev_edge;
  logic              key_hit, key_held, released, wr, rd, match;

  // active level per port after polarity; one loop per gpio
  genvar g;
  generate
    for (g = 0; g < N_GPIO; g++) begin : g_port
      assign active_lvl[g] = sync2_r[g] ^ pol_r[g];              // RQ2
      // pol 0: rising, pol 1: falling
      assign act_edge[g] = sel_r[g] & active_lvl[g]
                           & ~(prev_r[g] ^ pol_r[g]);            // RQ3 RQ4 RQ1
      assign rev_edge[g] = sel_r[g] & ~active_lvl[g]
                           & (prev_r[g] ^ pol_r[g]);

      // per-port edge checks; rise and fall written from the pin levels, not act_edge
      property p_rise_pick;
        @(posedge sys_clk_i) disable iff (rst_i)
        (sel_r[g] && !pol_r[g] && sync2_r[g] && !prev_r[g]) |-> act_edge[g];
      endproperty
      a_rise_pick: assert property (p_rise_pick) // RQ3
        else $error("no rise");

      property p_fall_pick;
        @(posedge sys_clk_i) disable iff (rst_i)
        (sel_r[g] && pol_r[g] && !sync2_r[g] && prev_r[g]) |-> act_edge[g];
      endproperty
      a_fall_pick: assert property (p_fall_pick) // RQ4
        else $error("no fall");

      property p_unsel_quiet;
        @(posedge sys_clk_i) disable iff (rst_i)
        !sel_r[g] |-> !(act_edge[g] || rev_edge[g]);
      endproperty
      a_unsel_quiet: assert property (p_unsel_quiet) // RQ1
        else $error("unselected edge");
    end
  endgenerate

  assign key_hit  = |act_edge;
  assign key_held = |(sel_r & active_lvl);
  assign released = ~key_held;

  // one wait state per access; a write lands on the edge that ends it,
  // so the master must hold its data until the edge that samples waitrequest low
  assign wr    = avs_write_i & ack_r;
  assign rd    = avs_read_i & ~ack_r;
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_r;
  assign avs_readdata_o    = rdata_r;
  assign wakeup_irq_o      = irq_r;                              // RQ14
  assign match = (cnt_r == cmp_r);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sync1_r <= '0;
      sync2_r <= '0;
      prev_r  <= '0;
    end else begin
      sync1_r <= gpio_i;                                         // RQ15
      sync2_r <= sync1_r;                                        // RQ15
      prev_r  <= sync2_r;
    end
  end

  // 1 ms tick
  always_comb begin
    tick_nxt     = 1'b0;
    tick_cnt_nxt = tick_cnt_r + 32'h0000_0001;
    if (tick_cnt_r == 32'(TICK_PERIOD - 1)) begin
      tick_cnt_nxt = ZERO32;
      tick_nxt     = 1'b1;                                       // RQ6
    end
  end

  // registers and bus
  always_comb begin
    sel_nxt   = sel_r;
    pol_nxt   = pol_r;
    ctrl_nxt  = ctrl_r;
    cmp_nxt   = cmp_r;
    ack_nxt   = (avs_read_i | avs_write_i) & ~ack_r;
    rdata_nxt = rdata_r;
    if (wr) begin
      case (avs_address_i)
        ADDR_PORT_EVENT_SELECT:  sel_nxt = avs_writedata_i[N_GPIO-1:0]; // RQ1
        ADDR_PORT_EDGE_POLARITY: pol_nxt = avs_writedata_i[N_GPIO-1:0]; // RQ2
        ADDR_WAKEUP_CONTROL:     ctrl_nxt = avs_writedata_i[CTRL_W-1:0];
        ADDR_EVENT_COMPARE:      cmp_nxt = avs_writedata_i[CNT_W-1:0];
        default: ;
      endcase
    end
    if (rd) begin
      case (avs_address_i)
        ADDR_PORT_EVENT_SELECT:  rdata_nxt = 32'(sel_r);
        ADDR_PORT_EDGE_POLARITY: rdata_nxt = 32'(pol_r);
        ADDR_WAKEUP_CONTROL:     rdata_nxt = 32'(ctrl_r);
        ADDR_EVENT_COMPARE:      rdata_nxt = 32'(cmp_r);
        ADDR_EVENT_COUNT:        rdata_nxt = 32'(cnt_r);         // RQ13
        ADDR_STATUS:             rdata_nxt = {ZERO32[31:3], irq_r,
                                              state_r};
        default:                 rdata_nxt = ZERO32;
      endcase
    end
  end

  // event state machine, counter and interrupt
  always_comb begin
    state_nxt = state_r;
    deb_nxt   = deb_r;
    cnt_nxt   = cnt_r;
    irq_nxt   = irq_r;
    case (state_r)
      WKC_IDLE: begin
        if (key_hit) begin
          deb_nxt   = ctrl_r[DEB_LSB +: DEB_W];                 // RQ5 RQ7
          state_nxt = WKC_DEBOUNCE;
        end
      end
      WKC_DEBOUNCE: begin
        if (!key_held) begin
          state_nxt = WKC_IDLE;                                  // RQ8
        end else if (deb_r == '0) begin
          cnt_nxt   = cnt_r + 8'h01;                             // RQ8
          state_nxt = WKC_WAIT_RELEASE;
        end else if (tick_r) begin
          deb_nxt = deb_r - 6'h01;                               // RQ6
        end
      end
      WKC_WAIT_RELEASE: begin
        if (released || (|rev_edge)) begin
          state_nxt = WKC_IDLE;                                  // RQ9
        end
      end
      default: state_nxt = WKC_IDLE;
    endcase
    if (match && cmp_r != '0) begin
      cnt_nxt = '0;                                              // RQ10
      if (ctrl_r[IRQ_EN_BIT]) begin
        irq_nxt = 1'b1;                                          // RQ10
      end
    end
    if (wr && avs_address_i == ADDR_COUNTER_CLEAR) begin
      cnt_nxt = '0;                                              // RQ12
    end
    // clear loses to a same-cycle new enabled match
    if (wr && avs_address_i == ADDR_IRQ_CLEAR &&
        !(match && cmp_r != '0 && ctrl_r[IRQ_EN_BIT])) begin
      irq_nxt = 1'b0;                                            // RQ11
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      sel_r      <= '0;
      pol_r      <= '0;
      ctrl_r     <= '0;
      cmp_r      <= '0;
      cnt_r      <= '0;
      deb_r      <= '0;
      tick_cnt_r <= ZERO32;
      tick_r     <= 1'b0;
      irq_r      <= 1'b0;
      ack_r      <= 1'b0;
      rdata_r    <= ZERO32;
      state_r    <= WKC_IDLE;
    end else begin
      sel_r      <= sel_nxt;
      pol_r      <= pol_nxt;
      ctrl_r     <= ctrl_nxt;
      cmp_r      <= cmp_nxt;
      cnt_r      <= cnt_nxt;
      deb_r      <= deb_nxt;
      tick_cnt_r <= tick_cnt_nxt;
      tick_r     <= tick_nxt;
      irq_r      <= irq_nxt;
      ack_r      <= ack_nxt;
      rdata_r    <= rdata_nxt;
      state_r    <= state_nxt;
    end
  end

  property p_sync_path;
    @(posedge sys_clk_i) disable iff (rst_i)
    1'b1 |=> (sync2_r == $past(sync1_r));
  endproperty
  a_sync_path: assert property (p_sync_path) else $error("sync bad"); // RQ15

  property p_deb_load;
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_r == WKC_IDLE && key_hit) |=>
      (state_r == WKC_DEBOUNCE && deb_r == $past(ctrl_r[DEB_W-1:0]));
  endproperty
  a_deb_load: assert property (p_deb_load) else $error("no load"); // RQ5

  property p_deb_step;
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_r == WKC_DEBOUNCE && key_held && deb_r != '0 && tick_r) |=>
      (deb_r == $past(deb_r) - 6'h01);
  endproperty
  a_deb_step: assert property (p_deb_step) else $error("no step"); // RQ6

  property p_deb_hold;
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_r == WKC_DEBOUNCE && !tick_r) |=> $stable(deb_r);
  endproperty
  a_deb_hold: assert property (p_deb_hold) else $error("deb moved"); // RQ6

  property p_drop;
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_r == WKC_DEBOUNCE && !key_held) |=> state_r == WKC_IDLE;
  endproperty
  a_drop: assert property (p_drop) else $error("bounce counted"); // RQ8

  property p_idle_no_hit;
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_r == WKC_IDLE && !key_hit) |=> state_r == WKC_IDLE;
  endproperty
  a_idle_no_hit: assert property (p_idle_no_hit) else $error("spurious"); // RQ1

  property p_wait_rel;
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_r == WKC_WAIT_RELEASE && key_held && !(|rev_edge)) |=>
      state_r == WKC_WAIT_RELEASE;
  endproperty
  a_wait_rel: assert property (p_wait_rel) else $error("early idle"); // RQ9

  property p_irq_set;
    @(posedge sys_clk_i) disable iff (rst_i)
    (match && cmp_r != '0 && ctrl_r[IRQ_EN_BIT]) |=>
      (irq_r && cnt_r == '0);
  endproperty
  a_irq_set: assert property (p_irq_set) else $error("no irq"); // RQ10

  property p_irq_clr;
    @(posedge sys_clk_i) disable iff (rst_i)
    (wr && avs_address_i == ADDR_IRQ_CLEAR &&
     !(match && cmp_r != '0 && ctrl_r[IRQ_EN_BIT])) |=> !wakeup_irq_o;
  endproperty
  a_irq_clr: assert property (p_irq_clr) else $error("irq stuck"); // RQ11

  property p_cnt_clr;
    @(posedge sys_clk_i) disable iff (rst_i)
    (wr && avs_address_i == ADDR_COUNTER_CLEAR) |=> cnt_r == '0;
  endproperty
  a_cnt_clr: assert property (p_cnt_clr) else $error("cnt stuck"); // RQ12

  property p_cnt_read;
    @(posedge sys_clk_i) disable iff (rst_i)
    (rd && avs_address_i == ADDR_EVENT_COUNT) |=>
      avs_readdata_o == 32'($past(cnt_r));
  endproperty
  a_cnt_read: assert property (p_cnt_read) else $error("bad read"); // RQ13

  property p_tick_phase;
    @(posedge sys_clk_i) disable iff (rst_i)
    tick_r |-> (tick_cnt_r == ZERO32);
  endproperty
  a_tick_phase: assert property (p_tick_phase) // RQ6
    else $error("tick off phase");

  property p_deb_done;
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_r == WKC_DEBOUNCE && key_held && deb_r == '0 &&
     !(match && cmp_r != '0) &&
     !(wr && avs_address_i == ADDR_COUNTER_CLEAR)) |=>
      (cnt_r == $past(cnt_r) + 8'h01 && state_r == WKC_WAIT_RELEASE);
  endproperty
  a_deb_done: assert property (p_deb_done) // RQ8
    else $error("no count");

  property p_inc_source;
    @(posedge sys_clk_i) disable iff (rst_i)
    (cnt_r != '0 && cnt_r == $past(cnt_r) + 8'h01) |->
      ($past(state_r) == WKC_DEBOUNCE && $past(deb_r) == '0 &&
       $past(key_held));
  endproperty
  a_inc_source: assert property (p_inc_source) // RQ8
    else $error("stray count");

  property p_wait_exit;
    @(posedge sys_clk_i) disable iff (rst_i)
    (state_r == WKC_WAIT_RELEASE && !key_held) |=> state_r == WKC_IDLE;
  endproperty
  a_wait_exit: assert property (p_wait_exit) // RQ9
    else $error("stuck after release");

  property p_irq_masked;
    @(posedge sys_clk_i) disable iff (rst_i)
    (!irq_r && !ctrl_r[IRQ_EN_BIT]) |=> !wakeup_irq_o;
  endproperty
  a_irq_masked: assert property (p_irq_masked) // RQ10
    else $error("masked irq");

  property p_irq_hold;
    @(posedge sys_clk_i) disable iff (rst_i)
    (irq_r && !(wr && avs_address_i == ADDR_IRQ_CLEAR)) |=> wakeup_irq_o;
  endproperty
  a_irq_hold: assert property (p_irq_hold) // RQ11
    else $error("irq lost");

  property p_one_wait;
    @(posedge sys_clk_i) disable iff (rst_i)
    avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_one_wait: assert property (p_one_wait) // RQ13
    else $error("wait too long");

  property p_wr_lands;
    @(posedge sys_clk_i) disable iff (rst_i)
    (avs_write_i && !avs_waitrequest_o &&
     avs_address_i == ADDR_EVENT_COMPARE) |=>
      cmp_r == CNT_W'($past(avs_writedata_i));
  endproperty
  a_wr_lands: assert property (p_wr_lands) // RQ10
    else $error("write lost");

endmodule

// file: verification/wkc_gpio_model.sv
`timescale 1ns/1ps
module wkc_gpio_model #(
  parameter int N = 8
) (
  // clock and requested levels
  input  wire logic         sys_clk_i,
  input  wire logic [N-1:0] level_i,
  // pins seen by the block
  output logic      [N-1:0] gpio_o
);
  // pins are clean switches here; bounce is made by the bench's short pulses
  always @(posedge sys_clk_i) begin
    gpio_o <= level_i;
  end
endmodule

// file: verification/tb.sv
`timescale 1ns/1ps
module tb;
  import wkc_pkg::*;
  localparam int TP = 8;
  localparam int W  = 48;
  logic        sys_clk = 1'b0;
  logic        rst_i   = 1'b1;
  logic [3:0]  addr    = 4'h0;
  logic        rd_en   = 1'b0;
  logic        wr_en   = 1'b0;
  logic [31:0] wdata   = 32'h0;
  logic [31:0] rdata;
  logic        wait_o;
  logic [7:0]  lvl     = 8'h02;
  logic [7:0]  gpio;
  logic        irq;
  int          fails     = 0;
  int          tests_run = 0;

  always #50 sys_clk = ~sys_clk;

  wkc_gpio_model #(.N(8)) model_u (
    .sys_clk_i(sys_clk),
    .level_i  (lvl),
    .gpio_o   (gpio)
  );

  wkc_event_counter #(.N_GPIO(8), .TICK_PERIOD(TP)) dut_u (
    .sys_clk_i        (sys_clk),
    .rst_i            (rst_i),
    .avs_address_i    (addr),
    .avs_read_i       (rd_en),
    .avs_write_i      (wr_en),
    .avs_writedata_i  (wdata),
    .avs_readdata_o   (rdata),
    .avs_waitrequest_o(wait_o),
    .gpio_i           (gpio),
    .wakeup_irq_o     (irq)
  );

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    tests_run++;
    if (s !== e) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, s, e);
    end
  endtask

  // request held until the edge that samples waitrequest low
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    do @(posedge sys_clk); while (wait_o !== 1'b0);
    wr_en <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] v;
    @(posedge sys_clk);
    addr  <= a;
    rd_en <= 1'b1;
    do @(posedge sys_clk); while (wait_o !== 1'b0);
    v = rdata;
    rd_en <= 1'b0;
    chk(v, e);
  endtask

  task automatic flip(input int p, input int w);
    @(posedge sys_clk);
    lvl[p] <= ~lvl[p];
    repeat (w) @(posedge sys_clk);
  endtask

  // active edge, then the reverse edge, each left long enough to settle
  task automatic ev(input int p);
    flip(p, W);
    flip(p, W);
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  initial begin
    #3000000;
    fails++;
    complete_run;
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    rst_i <= 1'b0;
    rd(ADDR_EVENT_COUNT, 32'h0);
    rd(4'h8, 32'h0);
    wr(ADDR_EVENT_COUNT, 32'h5);
    rd(ADDR_EVENT_COUNT, 32'h0);
    wr(ADDR_WAKEUP_CONTROL, 32'hBF);
    rd(ADDR_WAKEUP_CONTROL, 32'hBF);
    wr(ADDR_PORT_EVENT_SELECT, 32'h3);
    wr(ADDR_PORT_EDGE_POLARITY, 32'h2);
    rd(ADDR_PORT_EDGE_POLARITY, 32'h2);
    wr(ADDR_WAKEUP_CONTROL, 32'h2);
    wr(ADDR_EVENT_COMPARE, 32'h0);
    $display("test 1 done");
    flip(0, W);
    rd(ADDR_EVENT_COUNT, 32'h1);
    repeat (W) @(posedge sys_clk);
    rd(ADDR_EVENT_COUNT, 32'h1);
    flip(0, W);
    ev(0);
    rd(ADDR_EVENT_COUNT, 32'h2);
    ev(1);
    rd(ADDR_EVENT_COUNT, 32'h3);
    ev(2);
    rd(ADDR_EVENT_COUNT, 32'h3);
    $display("test 2 done");
    flip(0, 3);
    flip(0, W);
    rd(ADDR_EVENT_COUNT, 32'h3);
    wr(ADDR_WAKEUP_CONTROL, 32'h5);
    flip(0, 2 * TP);
    rd(ADDR_EVENT_COUNT, 32'h3);
    repeat (5 * TP) @(posedge sys_clk);
    rd(ADDR_EVENT_COUNT, 32'h4);
    flip(0, W);
    wr(ADDR_COUNTER_CLEAR, 32'h0);
    rd(ADDR_EVENT_COUNT, 32'h0);
    $display("test 3 done");
    wr(ADDR_WAKEUP_CONTROL, 32'h2);
    wr(ADDR_EVENT_COMPARE, 32'h2);
    ev(0);
    ev(0);
    rd(ADDR_EVENT_COUNT, 32'h0);
    chk({31'h0, irq}, 32'h0);
    wr(ADDR_WAKEUP_CONTROL, 32'h82);
    ev(0);
    rd(ADDR_EVENT_COUNT, 32'h1);
    ev(0);
    rd(ADDR_EVENT_COUNT, 32'h0);
    chk({31'h0, irq}, 32'h1);
    wr(ADDR_IRQ_CLEAR, 32'hA5);
    // the clear lands on the closing edge; look one edge later
    @(posedge sys_clk);
    chk({31'h0, irq}, 32'h0);
    $display("test 4 done");
    complete_run;
  end
endmodule
